// file: sea_pkg.sv
`default_nettype none
package sea_pkg;
  // default count of error checker lines feeding the aggregator
  localparam int unsigned NUM_SRC = 8;
  // reset values of the per-source and aggregate state
  localparam logic PEND_RST = 1'b0;
  localparam logic EN_RST   = 1'b0;
  localparam logic IRQ_RST  = 1'b0;
  localparam logic IDLE_RST = 1'b1;
  // handshake states of the clockstop/reset request
  typedef enum logic [1:0] {
    SEA_RUN,
    SEA_DRAIN,
    SEA_STOPPED
  } sea_stop_e;
endpackage
`default_nettype wire

// file: sea_src_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser with rising edge detect for checker event lines
module sea_src_sync #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  // raw event levels
  input  wire logic [W-1:0] evt_in,
  // one-cycle event pulses
  output logic      [W-1:0] evt_pulse_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] last_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;
  logic [W-1:0] nxt_last;

  always_comb begin
    nxt_meta = evt_in;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  assign evt_pulse_out = sync_ff & ~last_ff;

  pulse_single_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (evt_pulse_out & $past(evt_pulse_out)) == '0)
    else $error("event pulse longer than one cycle");
endmodule // sea_src_sync
`default_nettype wire

// file: sea_aggregator.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - checker events raise software interrupt
// - software enables, disables and clears each
// - not idle while any flag pending
// - stop acknowledge only once aggregator idle
module sea_aggregator #(
  parameter int unsigned N = sea_pkg::NUM_SRC
) (
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  // error checker event levels
  input  wire logic [N-1:0] err_evt_in,
  // software control
  input  wire logic [N-1:0] irq_en_set_in,
  input  wire logic [N-1:0] irq_en_clr_in,
  input  wire logic [N-1:0] pend_clr_in,
  // software status
  output logic      [N-1:0] pend_out,
  output logic      [N-1:0] irq_en_out,
  output logic              irq_out,
  // clockstop/reset sequencer handshake
  input  wire logic         stop_req_in,
  output logic              idle_out,
  output logic              stop_ack_out
);
  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic any_set(input logic [N-1:0] v);
    return |v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // event capture
  logic [N-1:0] evt_pulse;

  sea_src_sync #(.W(N)) u_sync (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .evt_in        (err_evt_in),
    .evt_pulse_out (evt_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pending and enable state
  logic [N-1:0] pend_ff;
  logic [N-1:0] en_ff;
  logic [N-1:0] nxt_pend;
  logic [N-1:0] nxt_en;
  logic         irq_ff;
  logic         nxt_irq;

  always_comb begin
    // set wins over a simultaneous clear
    nxt_pend = (pend_ff & ~pend_clr_in) | evt_pulse;
    nxt_en   = (en_ff & ~irq_en_clr_in) | irq_en_set_in;
    nxt_irq  = any_set(nxt_pend & nxt_en);
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pend_ff <= {N{sea_pkg::PEND_RST}};
      en_ff   <= {N{sea_pkg::EN_RST}};
      irq_ff  <= sea_pkg::IRQ_RST;
    end else begin
      pend_ff <= nxt_pend;
      en_ff   <= nxt_en;
      irq_ff  <= nxt_irq;
    end
  end

  assign pend_out   = pend_ff;
  assign irq_en_out = en_ff;
  assign irq_out    = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // idle and stop handshake
  sea_pkg::sea_stop_e st_ff;
  sea_pkg::sea_stop_e nxt_st;
  logic               idle_ff;
  logic               nxt_idle;

  always_comb begin
    nxt_idle = ~any_set(nxt_pend);
    nxt_st   = st_ff;
    unique case (st_ff)
      sea_pkg::SEA_RUN: begin
        if (stop_req_in) begin
          nxt_st = sea_pkg::SEA_DRAIN;
        end
      end
      sea_pkg::SEA_DRAIN: begin
        if (!stop_req_in) begin
          nxt_st = sea_pkg::SEA_RUN;
        end else if (idle_ff) begin
          nxt_st = sea_pkg::SEA_STOPPED;
        end
      end
      sea_pkg::SEA_STOPPED: begin
        if (!stop_req_in) begin
          nxt_st = sea_pkg::SEA_RUN;
        end else if (!idle_ff) begin
          nxt_st = sea_pkg::SEA_DRAIN;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_ff   <= sea_pkg::SEA_RUN;
      idle_ff <= sea_pkg::IDLE_RST;
    end else begin
      st_ff   <= nxt_st;
      idle_ff <= nxt_idle;
    end
  end

  assign idle_out     = idle_ff;
  // gated by idle so a flag pending in the stopped state drops the ack at once
  assign stop_ack_out = (st_ff == sea_pkg::SEA_STOPPED) && idle_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  pend_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (evt_pulse != '0) |=> ((pend_ff & $past(evt_pulse)) == $past(evt_pulse)))
    else $error("event did not set pending flag");

  pend_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (pend_ff[0] && !pend_clr_in[0]) |=> pend_ff[0])
    else $error("pending flag lost without clear");

  pend_clear_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (pend_clr_in[0] && !evt_pulse[0]) |=> !pend_ff[0])
    else $error("clear did not drop pending flag");

  en_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    irq_en_set_in[0] |=> en_ff[0])
    else $error("enable set ignored");

  idle_pend_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    |pend_ff |-> !idle_ff)
    else $error("idle while a flag pending");

  idle_clear_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (pend_ff == '0) |-> idle_ff)
    else $error("not idle with nothing pending");

  ack_idle_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    stop_ack_out |-> $past(idle_ff))
    else $error("stop acknowledged while not idle");

  ack_reach_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (stop_req_in && idle_ff && !stop_ack_out) [*2] |=> (st_ff == sea_pkg::SEA_STOPPED))
    else $error("stop not acknowledged once idle");

  irq_gate_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    irq_out == (|(pend_ff & en_ff)))
    else $error("interrupt not gated by enable");

  irq_mask_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (en_ff == '0) |-> !irq_out)
    else $error("interrupt with all sources disabled");

  idle_irq_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    irq_out |-> !idle_ff)
    else $error("idle while an interrupt is raised");

  ack_now_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    stop_ack_out |-> idle_ff)
    else $error("stop acknowledged with a flag pending");

  stop_wait_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (stop_req_in && !idle_ff) |=> !stop_ack_out)
    else $error("stop acknowledged before idle");

  run_no_ack_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !stop_req_in |=> !stop_ack_out)
    else $error("stop acknowledged without request");

  drain_enter_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ((st_ff == sea_pkg::SEA_RUN) && stop_req_in) |=> (st_ff == sea_pkg::SEA_DRAIN))
    else $error("request did not start the drain");

  // per-source flag and enable behaviour
  for (genvar g = 0; g < N; g++) begin : g_src_chk
    pend_rise_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      evt_pulse[g] |=> pend_ff[g])
      else $error("event lost on a source");

    pend_quiet_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (!pend_ff[g] && !evt_pulse[g]) |=> !pend_ff[g])
      else $error("flag set with no event");

    pend_keep_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (pend_ff[g] && !pend_clr_in[g]) |=> pend_ff[g])
      else $error("flag dropped with no clear");

    pend_drop_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (pend_clr_in[g] && !evt_pulse[g]) |=> !pend_ff[g])
      else $error("flag kept after a clear");

    en_rise_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      irq_en_set_in[g] |=> en_ff[g])
      else $error("enable set lost on a source");

    en_drop_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (irq_en_clr_in[g] && !irq_en_set_in[g]) |=> !en_ff[g])
      else $error("enable kept after a clear");

    en_keep_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (en_ff[g] && !irq_en_clr_in[g]) |=> en_ff[g])
      else $error("enable dropped with no clear");
  end
endmodule // sea_aggregator
`default_nettype wire

// file: sea_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// sequencer side: holds stop request until acknowledged
module sea_seq_model (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  // bench command and handshake
  input  wire logic go_in,
  input  wire logic safety_in,
  input  wire logic stop_ack_in,
  output logic      stop_req_out
);
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) stop_req_out <= 1'b0;
    else if (go_in && !safety_in) stop_req_out <= 1'b1;
    else if (stop_ack_in) stop_req_out <= 1'b0;
  end
endmodule // sea_seq_model
`default_nettype wire

// file: safety_error_aggregator_idle_test.sv
`timescale 1ns/1ps
`default_nettype none
module safety_error_aggregator_idle_test;
  localparam int unsigned N = sea_pkg::NUM_SRC;
  typedef struct packed {logic [7:0] en; logic [7:0] evt; logic irq;} sea_row_s;
  logic         core_clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  logic [N-1:0] err_evt = '0, en_set = '0, en_clr = '0, pend_clr = '0;
  logic [N-1:0] pend, en;
  logic         irq, idle, req, ack;
  logic         go = 1'b0;
  logic         safety = 1'b0;
  int           n_errors = 0;
  int           checks = 0;
  int           cyc = 0;
  sea_row_s     rows [4] = '{'{8'h00, 8'h01, 1'b0}, '{8'h01, 8'h01, 1'b1},
                             '{8'h80, 8'h81, 1'b1}, '{8'h02, 8'h01, 1'b0}};
  ////////////////////////////////////////////////////////////////
  sea_aggregator #(.N(N)) dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .err_evt_in(err_evt), .irq_en_set_in(en_set), .irq_en_clr_in(en_clr),
    .pend_clr_in(pend_clr), .pend_out(pend), .irq_en_out(en), .irq_out(irq),
    .stop_req_in(req), .idle_out(idle), .stop_ack_out(ack));
  sea_seq_model seq_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .go_in(go),
    .safety_in(safety), .stop_ack_in(ack), .stop_req_out(req));
  ////////////////////////////////////////////////////////////////
  always #20 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic step(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    step(6);
    check({ack, irq, idle, pend, en}, 19'h10000);
    rst_n_in = 1'b1;
    foreach (rows[i]) begin
      en_set = rows[i].en;
      en_clr = '1;
      err_evt = rows[i].evt;
      step(1);
      en_set = '0;
      en_clr = '0;
      err_evt = '0;
      step(5);
      check(pend, rows[i].evt);
      check(en, rows[i].en);
      check({irq, idle}, {rows[i].irq, 1'b0});
      pend_clr = rows[i].evt;
      step(1);
      pend_clr = '0;
      step(1);
      check({irq, idle, pend}, 10'h100);
    end
    // an event beats a clear in the same cycle
    err_evt = 8'h02;
    step(2);
    pend_clr = 8'h02;
    step(1);
    err_evt = '0;
    pend_clr = '0;
    check({irq, pend}, 9'h102);
    pend_clr = 8'h02;
    step(1);
    pend_clr = '0;
    check({irq, idle, pend}, 10'h100);
    en_clr = '1;
    step(1);
    en_clr = '0;
    check(en, 8'h00);
    // no request while a safety use-case runs
    safety = 1'b1;
    go = 1'b1;
    step(1);
    go = 1'b0;
    step(2);
    check({req, ack}, 2'b00);
    safety = 1'b0;
    // stop with a flag pending, serviced during the sequence
    en_set = '1;
    step(1);
    en_set = '0;
    err_evt = 8'h04;
    step(1);
    err_evt = '0;
    step(5);
    go = 1'b1;
    step(1);
    go = 1'b0;
    step(10);
    check({req, ack, idle, irq}, 4'h9);
    // source refires into the clear, then its checker is silenced
    err_evt = 8'h04;
    step(1);
    err_evt = '0;
    step(1);
    pend_clr = 8'h04;
    step(1);
    pend_clr = '0;
    step(3);
    check({req, ack, idle, pend[2]}, 4'h9);
    pend_clr = 8'h04;
    step(1);
    pend_clr = '0;
    step(1);
    check({req, ack, idle}, 3'h7);
    step(6);
    check({req, ack}, 2'b00);
    // reset in mid-run with a flag pending and enabled
    err_evt = 8'h10;
    step(1);
    err_evt = '0;
    step(5);
    check({irq, idle, pend}, 10'h210);
    rst_n_in = 1'b0;
    step(2);
    rst_n_in = 1'b1;
    check({ack, irq, idle, pend, en}, 19'h10000);
    step(1);
    check({ack, irq, idle, pend, en}, 19'h10000);
    stop_test();
  end
endmodule // safety_error_aggregator_idle_test
`default_nettype wire
